// ==== sfr_framer.sv ====
// STS-1 frame builder and receive delineator with pointer tracking
`timescale 1ns/100ps
module sfr_framer
   import sfr_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [9:0] tx_ptr,
   input wire logic tx_ndf,
   input wire logic tx_rdi,
   input wire logic [7:0] tx_trace,
   input wire logic [7:0] tx_payload,
   output logic [7:0] tx_byte,
   output logic tx_byte_stb,
   output logic tx_take,
   output logic tx_frame_start,
   input wire logic [7:0] rx_byte_pin,
   input wire logic rx_stb_pin,
   output logic rx_lock,
   output logic [7:0] rx_data,
   output logic rx_data_stb,
   output logic rx_frame_start,
   output logic rx_toh,
   output logic rx_ptr_slot,
   output logic rx_ec,
   output logic rx_poh,
   output logic rx_spe_start,
   output logic [9:0] rx_ptr_val,
   output logic rx_inc,
   output logic rx_dec,
   output logic rx_ndf,
   output logic rx_b1_err,
   output logic rx_rdi,
   output logic [7:0] rx_trace
);
   sfr_pos_if txp ();
   sfr_pos_if rxp ();

   sfr_pos_ctr u_tx_pos (
      .mclk(mclk),
      .rstn(rstn),
      .pos(txp)
   );
   sfr_pos_ctr u_rx_pos (
      .mclk(mclk),
      .rstn(rstn),
      .pos(rxp)
   );

   // ======================================================================
   // Byte pacing: fractional accumulator gives 6.48 Mbyte/s on average
   logic [26:0] acc_q;
   logic [26:0] acc_sum;
   logic tick;

   always_comb begin
      acc_sum = acc_q + ACC_STEP;
      tick = acc_sum >= ACC_MOD;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         acc_q <= '0;
      end else begin
         acc_q <= tick ? acc_sum - ACC_MOD : acc_sum;
      end
   end

   // ======================================================================
   // Transmit byte selection
   logic [7:0] tx_sel;
   logic [7:0] tx_bip_q;
   logic [7:0] tx_b1_q;

   assign txp.adv = tick;
   assign txp.restart = 1'b0;

   // Unused overhead, DCC slots included, goes out as idle
   always_comb begin
      tx_sel = IDLE_BYTE;
      if (txp.ec) begin
         tx_sel = tx_payload;
      end else if (txp.row == ROW_FRAMING && txp.col == COL_0) begin
         tx_sel = FRAMING_A1;
      end else if (txp.row == ROW_FRAMING && txp.col == COL_1) begin
         tx_sel = FRAMING_A2;
      end else if (txp.row == ROW_FRAMING && txp.col == COL_2) begin
         tx_sel = tx_trace;
      end else if (txp.row == ROW_B1 && txp.col == COL_0) begin
         tx_sel = tx_b1_q;
      end else if (txp.ptr && txp.col == COL_0) begin
         tx_sel = {tx_ndf ? NDF_ON : NDF_OFF, 2'b00, tx_ptr[9:8]};
      end else if (txp.ptr && txp.col == COL_1) begin
         tx_sel = tx_ptr[7:0];
      end else if (txp.row == ROW_K2 && txp.col == COL_2) begin
         tx_sel = {5'h00, tx_rdi ? RDI_CODE : 3'h0};
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_byte <= IDLE_BYTE;
         tx_byte_stb <= 1'b0;
         tx_take <= 1'b0;
         tx_frame_start <= 1'b0;
      end else begin
         tx_byte_stb <= tick;
         tx_take <= tick && txp.ec;
         tx_frame_start <= tick && txp.row == ROW_FRAMING && txp.col == COL_0;
         if (tick) begin
            tx_byte <= tx_sel;
         end
      end
   end

   // Parity covers the whole previous frame as sent
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_bip_q <= 8'h00;
         tx_b1_q <= 8'h00;
      end else if (tick) begin
         if (txp.last) begin
            tx_b1_q <= tx_bip_q ^ tx_sel;
            tx_bip_q <= 8'h00;
         end else begin
            tx_bip_q <= tx_bip_q ^ tx_sel;
         end
      end
   end

   // ======================================================================
   // Receive pin synchronisers
   logic [7:0] rx_d1_q;
   logic [7:0] rx_d2_q;
   logic rx_s1_q;
   logic rx_s2_q;
   logic rx_s3_q;
   logic stb;
   logic [7:0] rb;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_d1_q <= 8'h00;
         rx_d2_q <= 8'h00;
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rx_s3_q <= 1'b0;
      end else begin
         rx_d1_q <= rx_byte_pin;
         rx_d2_q <= rx_d1_q;
         rx_s1_q <= rx_stb_pin;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   // Data must be steady a few cycles around the strobe's rising edge
   assign stb = rx_s2_q && !rx_s3_q;
   assign rb = rx_d2_q;

   // ======================================================================
   // Frame search and loss of frame
   sfr_rx_state_t st_q;
   logic [7:0] prev_q;
   logic [1:0] miss_q;
   logic bad_q;
   logic found;

   assign found = stb && st_q == st_hunt && prev_q == FRAMING_A1 && rb == FRAMING_A2;
   assign rxp.restart = found;
   assign rxp.adv = stb && st_q == st_sync;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= st_hunt;
         prev_q <= 8'h00;
         miss_q <= 2'h0;
         bad_q <= 1'b0;
      end else if (stb) begin
         prev_q <= rb;
         case (st_q)
            st_hunt: begin
               miss_q <= 2'h0;
               bad_q <= 1'b0;
               if (found) begin
                  st_q <= st_sync;
               end
            end
            st_sync: begin
               if (rxp.row == ROW_FRAMING && rxp.col == COL_0) begin
                  bad_q <= rb != FRAMING_A1;
               end else if (rxp.row == ROW_FRAMING && rxp.col == COL_1) begin
                  if (bad_q || rb != FRAMING_A2) begin
                     miss_q <= miss_q + 2'h1;
                     if (miss_q == OOF_FRAMES) begin
                        st_q <= st_hunt;
                     end
                  end else begin
                     miss_q <= 2'h0;
                  end
               end
            end
            default: st_q <= st_hunt;
         endcase
      end
   end

   // ======================================================================
   // Pointer interpretation
   logic [7:0] h1_q;
   logic [9:0] pnew;
   logic [9:0] pinv;
   logic at_h2;

   assign pnew = {h1_q[1:0], rb};
   assign pinv = pnew ^ rx_ptr_val;
   assign at_h2 = rxp.adv && rxp.ptr && rxp.col == COL_1;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         h1_q <= 8'h00;
         rx_ptr_val <= PTR_RESET;
         rx_inc <= 1'b0;
         rx_dec <= 1'b0;
         rx_ndf <= 1'b0;
      end else begin
         rx_inc <= 1'b0;
         rx_dec <= 1'b0;
         rx_ndf <= 1'b0;
         if (rxp.adv && rxp.ptr && rxp.col == COL_0) begin
            h1_q <= rb;
         end
         if (at_h2) begin
            if (h1_q[7:4] == NDF_ON && pnew <= PTR_MAX) begin
               rx_ptr_val <= pnew;
               rx_ndf <= 1'b1;
            end else if (pinv == PTR_I_BITS) begin
               rx_ptr_val <= (rx_ptr_val == PTR_MAX) ? PTR_RESET : rx_ptr_val + 10'h001;
               rx_inc <= 1'b1;
            end else if (pinv == PTR_D_BITS) begin
               rx_ptr_val <= (rx_ptr_val == PTR_RESET) ? PTR_MAX : rx_ptr_val - 10'h001;
               rx_dec <= 1'b1;
            end else if (pnew <= PTR_MAX) begin
               rx_ptr_val <= pnew;
            end
         end
      end
   end

   // ======================================================================
   // Envelope location: offset zero is the byte after H3
   logic [9:0] ec_idx_q;
   logic [9:0] ec_idx;
   logic [6:0] spe_col_q;
   logic [6:0] spe_col;
   logic spe_vld_q;
   logic spe_hit;

   always_comb begin
      ec_idx = (rxp.row == ROW_PTR && rxp.col == COL_EC0) ? 10'h000 : ec_idx_q + 10'h001;
      spe_hit = rxp.ec && ec_idx == rx_ptr_val;
      spe_col = (spe_hit || spe_col_q == SPE_COL_LAST) ? 7'h00 : spe_col_q + 7'h01;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ec_idx_q <= 10'h000;
         spe_col_q <= 7'h00;
         spe_vld_q <= 1'b0;
      end else if (found) begin
         spe_vld_q <= 1'b0;
      end else if (rxp.adv && rxp.ec) begin
         ec_idx_q <= ec_idx;
         spe_col_q <= spe_col;
         spe_vld_q <= spe_vld_q || spe_hit;
      end
   end

   // ======================================================================
   // Received byte, classes and overhead checks
   logic [7:0] rx_bip_q;
   logic [7:0] rx_b1_calc_q;
   logic b1_armed_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_lock <= 1'b0;
         rx_data <= 8'h00;
         rx_data_stb <= 1'b0;
         rx_frame_start <= 1'b0;
         rx_toh <= 1'b0;
         rx_ptr_slot <= 1'b0;
         rx_ec <= 1'b0;
         rx_poh <= 1'b0;
         rx_spe_start <= 1'b0;
      end else begin
         rx_lock <= st_q == st_sync;
         rx_data_stb <= rxp.adv;
         rx_frame_start <= found;
         if (rxp.adv) begin
            rx_data <= rb;
            rx_toh <= rxp.toh;
            rx_ptr_slot <= rxp.ptr;
            rx_ec <= rxp.ec;
            rx_poh <= rxp.ec && (spe_vld_q || spe_hit) && spe_col == 7'h00;
            rx_spe_start <= spe_hit;
         end else begin
            rx_poh <= 1'b0;
            rx_spe_start <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_bip_q <= 8'h00;
         rx_b1_calc_q <= 8'h00;
         b1_armed_q <= 1'b0;
         rx_b1_err <= 1'b0;
         rx_rdi <= 1'b0;
         rx_trace <= 8'h00;
      end else begin
         rx_b1_err <= 1'b0;
         if (found) begin
            rx_bip_q <= FRAMING_A1 ^ FRAMING_A2;
            b1_armed_q <= 1'b0;
         end else if (rxp.adv) begin
            if (rxp.last) begin
               rx_b1_calc_q <= rx_bip_q ^ rb;
               rx_bip_q <= 8'h00;
               b1_armed_q <= 1'b1;
            end else begin
               rx_bip_q <= rx_bip_q ^ rb;
            end
            if (rxp.row == ROW_B1 && rxp.col == COL_0) begin
               rx_b1_err <= b1_armed_q && rb != rx_b1_calc_q;
            end
            if (rxp.row == ROW_K2 && rxp.col == COL_2) begin
               rx_rdi <= rb[2:0] == RDI_CODE;
            end
            if (rxp.row == ROW_FRAMING && rxp.col == COL_2) begin
               rx_trace <= rb;
            end
         end
      end
   end

   // ======================================================================
   // Checks
   logic [9:0] tx_nb_q;
   logic tx_seen_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_nb_q <= 10'h000;
         tx_seen_q <= 1'b0;
      end else if (tx_frame_start) begin
         tx_nb_q <= 10'h000;
         tx_seen_q <= 1'b1;
      end else if (tx_byte_stb) begin
         tx_nb_q <= tx_nb_q + 10'h001;
      end
   end

   a_tx_frame_len: assert property (@(posedge mclk) disable iff (!rstn)
      tx_frame_start && tx_seen_q |-> tx_nb_q == 10'(FRAME_BYTES - 1))
      else $error("frame not 810 bytes");
   a_tx_byte_pace: assert property (@(posedge mclk) disable iff (!rstn)
      tx_byte_stb |=> !tx_byte_stb [*8])
      else $error("bytes faster than line rate");
   a_tx_a1_first: assert property (@(posedge mclk) disable iff (!rstn)
      tx_frame_start |-> tx_byte_stb && tx_byte == FRAMING_A1)
      else $error("frame does not open with A1");
   a_tx_take_ec: assert property (@(posedge mclk) disable iff (!rstn)
      tx_take |-> tx_byte_stb && tx_byte == $past(tx_payload))
      else $error("payload take without envelope byte");
   a_rx_sync_found: assert property (@(posedge mclk) disable iff (!rstn)
      found |=> ##1 rx_lock && rx_frame_start == 1'b0)
      else $error("lock not taken after framing");
   a_rx_class_split: assert property (@(posedge mclk) disable iff (!rstn)
      rx_data_stb |-> rx_toh != rx_ec)
      else $error("byte both overhead and envelope");
   a_rx_ptr_toh: assert property (@(posedge mclk) disable iff (!rstn)
      rx_ptr_slot |-> rx_toh && !rx_ec)
      else $error("pointer slot outside overhead");
   a_rx_poh_ec: assert property (@(posedge mclk) disable iff (!rstn)
      rx_poh |-> rx_ec && rx_data_stb)
      else $error("path overhead outside envelope");
   a_rx_ptr_range: assert property (@(posedge mclk) disable iff (!rstn)
      rx_inc || rx_dec || rx_ndf |-> rx_ptr_val <= PTR_MAX && !(rx_inc && rx_dec))
      else $error("pointer out of range");
endmodule

// ==== sfr_pkg.sv ====
// Package of constants and types for the STS-1 frame-structure framer
package sfr_pkg;
   // ======================================================================
   // Frame geometry
   localparam int ROWS = 9;
   localparam int COLS = 90;
   localparam int TOH_COLS = 3;
   localparam int EC_COLS = 87;
   localparam int FRAME_BYTES = 810;
   localparam int FRAME_BITS = 6480;
   localparam int FRAME_RATE = 8000;
   localparam int LINE_BPS = FRAME_BITS * FRAME_RATE;
   // ======================================================================
   // Byte pacing from the 100 MHz clock
   localparam int CLK_HZ = 100_000_000;
   localparam int BYTE_RATE = FRAME_RATE * FRAME_BYTES;
   localparam logic [26:0] ACC_STEP = 27'(BYTE_RATE);
   localparam logic [26:0] ACC_MOD = 27'(CLK_HZ);
   // ======================================================================
   // Overhead byte positions (row, column), counted from zero
   localparam logic [3:0] ROW_FRAMING = 4'h0;
   localparam logic [3:0] ROW_B1 = 4'h1;
   localparam logic [3:0] ROW_PTR = 4'h3;
   localparam logic [3:0] ROW_K2 = 4'h4;
   localparam logic [3:0] ROW_LAST = 4'h8;
   localparam logic [6:0] COL_0 = 7'h00;
   localparam logic [6:0] COL_1 = 7'h01;
   localparam logic [6:0] COL_2 = 7'h02;
   localparam logic [6:0] COL_EC0 = 7'h03;
   localparam logic [6:0] COL_LAST = 7'h59;
   localparam logic [6:0] SPE_COL_LAST = 7'h56;
   // ======================================================================
   // Byte values and pointer fields
   localparam logic [7:0] FRAMING_A1 = 8'hf6;
   localparam logic [7:0] FRAMING_A2 = 8'h28;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   localparam logic [3:0] NDF_ON = 4'h9;
   localparam logic [3:0] NDF_OFF = 4'h6;
   localparam logic [9:0] PTR_MAX = 10'h30e;
   localparam logic [9:0] PTR_I_BITS = 10'h2aa;
   localparam logic [9:0] PTR_D_BITS = 10'h155;
   localparam logic [9:0] PTR_RESET = 10'h000;
   localparam logic [2:0] RDI_CODE = 3'h6;
   localparam logic [1:0] OOF_FRAMES = 2'h3;
   typedef enum logic {st_hunt, st_sync} sfr_rx_state_t;
endpackage

// ==== sfr_pos_if.sv ====
// Interface carrying a frame position counter and its byte-class flags
`timescale 1ns/100ps
interface sfr_pos_if;
   logic adv;
   logic restart;
   logic [3:0] row;
   logic [6:0] col;
   logic toh;
   logic ptr;
   logic ec;
   logic last;
   modport ctr (input adv, input restart, output row, output col, output toh,
      output ptr, output ec, output last);
   modport user (output adv, output restart, input row, input col, input toh,
      input ptr, input ec, input last);
endinterface

// ==== sfr_pos_ctr.sv ====
// Row and column counter of one frame slot, with registered byte-class flags
`timescale 1ns/100ps
module sfr_pos_ctr
   import sfr_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   sfr_pos_if.ctr pos
);
   logic [3:0] row_d;
   logic [6:0] col_d;

   // ======================================================================
   // Next slot: row by row, left to right, wrap with no gap
   always_comb begin
      row_d = pos.row;
      col_d = pos.col;
      if (pos.restart) begin
         row_d = ROW_FRAMING;
         col_d = COL_2;
      end else if (pos.adv) begin
         if (pos.col == COL_LAST) begin
            col_d = COL_0;
            row_d = (pos.row == ROW_LAST) ? ROW_FRAMING : pos.row + 4'h1;
         end else begin
            col_d = pos.col + 7'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pos.row <= ROW_FRAMING;
         pos.col <= COL_0;
         pos.toh <= 1'b1;
         pos.ptr <= 1'b0;
         pos.ec <= 1'b0;
         pos.last <= 1'b0;
      end else begin
         pos.row <= row_d;
         pos.col <= col_d;
         pos.toh <= col_d < COL_EC0;
         pos.ptr <= (row_d == ROW_PTR) && (col_d < COL_EC0);
         pos.ec <= col_d >= COL_EC0;
         pos.last <= (row_d == ROW_LAST) && (col_d == COL_LAST);
      end
   end

   a_slot_in_frame: assert property (@(posedge mclk) disable iff (!rstn)
      (pos.row < 4'(ROWS)) && (pos.col < 7'(COLS)))
      else $error("slot outside 9 by 90 frame");
   a_class_split: assert property (@(posedge mclk) disable iff (!rstn)
      pos.adv && !pos.restart && pos.col == COL_2 |=> pos.ec && !pos.toh)
      else $error("overhead not three columns wide");
endmodule

// ==== sfr_far_end.sv ====
// Far-end element model that loops the line stream back onto the receive pins
`timescale 1ns/100ps
module sfr_far_end
   import sfr_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] line_byte,
   input wire logic line_stb,
   input wire logic line_a1,
   input wire logic bad_a1,
   output logic [7:0] pin_byte,
   output logic pin_stb
);
   logic [3:0] ph_q;
   // ==========================================================================
   // Byte relay
   // Strobe rises 4 cycles after the data and falls 4 later, so both setup and
   // hold are met with margin inside the shortest 15-cycle byte slot
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ph_q <= 4'h0;
         pin_stb <= 1'b0;
         pin_byte <= 8'h00;
      end else if (line_stb) begin
         pin_byte <= (bad_a1 && line_a1) ? ~line_byte : line_byte;
         ph_q <= 4'h1;
      end else if (ph_q != 4'h0) begin
         ph_q <= (ph_q == 4'hc) ? 4'h0 : ph_q + 4'h1;
         if (ph_q == 4'h4) begin
            pin_stb <= 1'b1;
         end
         if (ph_q == 4'h8) begin
            pin_stb <= 1'b0;
         end
         // Hold time over: show junk rather than the stale byte
         if (ph_q == 4'hc) begin
            pin_byte <= ~pin_byte;
         end
      end
   end
endmodule

// ==== sfr_framer_bench.sv ====
// Self-checking bench for the framer with a looped-back far end
`timescale 1ns/100ps
module sfr_framer_bench;
   import sfr_pkg::*;
   logic mclk, rstn, tx_ndf, tx_rdi, bad_a1, rx_stb_pin;
   logic [9:0] tx_ptr, rx_ptr_val;
   logic [7:0] tx_trace, tx_payload, tx_byte, rx_byte_pin, rx_data, rx_trace, exp_b;
   logic [7:0] par = 8'h00, b1_prev = 8'h00, trace_v;
   logic tx_byte_stb, tx_take, tx_frame_start, rx_lock, rx_data_stb, rx_frame_start;
   logic rx_toh, rx_ptr_slot, rx_ec, rx_poh, rx_spe_start, rx_inc, rx_dec, rx_ndf;
   logic rx_b1_err, rx_rdi;
   int error_cnt = 0, num_checks = 0, pos = 0, rpos = 0, rx_frm = 0, gap = 0, cyc = 0;
   int fs_cyc = -1, inc_n = 0, dec_n = 0, ndf_n = 0, b1_n = 0, lock_n = 0, p = 100;
   int r, c, off;

   sfr_framer dut_u (.mclk, .rstn, .tx_ptr, .tx_ndf, .tx_rdi, .tx_trace, .tx_payload,
      .tx_byte, .tx_byte_stb, .tx_take, .tx_frame_start, .rx_byte_pin, .rx_stb_pin,
      .rx_lock, .rx_data, .rx_data_stb, .rx_frame_start, .rx_toh, .rx_ptr_slot, .rx_ec,
      .rx_poh, .rx_spe_start, .rx_ptr_val, .rx_inc, .rx_dec, .rx_ndf, .rx_b1_err,
      .rx_rdi, .rx_trace);
   sfr_far_end far_u (.mclk, .rstn, .line_byte(tx_byte), .line_stb(tx_byte_stb),
      .line_a1(tx_frame_start), .bad_a1, .pin_byte(rx_byte_pin), .pin_stb(rx_stb_pin));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ==========================================================================
   // Checking helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wait_sig(ref logic s, input logic v);
      int n;
      n = 0;
      @(negedge mclk);
      while (s !== v && n < 13000) begin
         @(negedge mclk);
         n++;
      end
      if (s !== v) begin
         error_cnt++;
         finish_test();
      end
   endtask

   function automatic logic [7:0] toh_byte(int r, int c);
      if (r == 0 && c == 0) return FRAMING_A1;
      if (r == 0 && c == 1) return FRAMING_A2;
      if (r == 0 && c == 2) return tx_trace;
      if (r == 1 && c == 0) return b1_prev;
      if (r == 3 && c == 0) return {tx_ndf ? NDF_ON : NDF_OFF, 2'b00, tx_ptr[9:8]};
      if (r == 3 && c == 1) return tx_ptr[7:0];
      if (r == 4 && c == 2) return {5'h00, tx_rdi ? RDI_CODE : 3'h0};
      return IDLE_BYTE;
   endfunction

   // ==========================================================================
   // Monitors, sampled on the falling edge where outputs have settled
   always @(negedge mclk) begin
      if (rstn) begin
         cyc++;
         gap++;
         if (tx_byte_stb) begin
            r = pos / COLS;
            c = pos % COLS;
            exp_b = (c >= TOH_COLS) ? tx_payload : toh_byte(r, c);
            if (fs_cyc >= 0) check(32'(gap == 15 || gap == 16), 1);
            gap = 0;
            check(32'(tx_frame_start), 32'(pos == 0));
            check(32'(tx_take), 32'(c >= TOH_COLS));
            check(32'(tx_byte), 32'(exp_b));
            par = par ^ exp_b;
            if (tx_frame_start) begin
               if (fs_cyc >= 0) check(cyc - fs_cyc, CLK_HZ / FRAME_RATE);
               fs_cyc = cyc;
            end
            if (tx_take) tx_payload <= 8'($urandom);
            if (pos == FRAME_BYTES - 1) begin
               b1_prev = par;
               par = 8'h00;
            end
            pos = (pos + 1) % FRAME_BYTES;
         end
         if (rx_frame_start) begin
            rpos = 2;
            lock_n++;
         end
         if (rx_inc) inc_n++;
         if (rx_dec) dec_n++;
         if (rx_ndf) ndf_n++;
         if (rx_b1_err && rx_frm >= 2) b1_n++;
         if (rx_data_stb) begin
            r = rpos / COLS;
            c = rpos % COLS;
            off = ((r + 6) % ROWS) * EC_COLS + c - TOH_COLS;
            check(32'(rx_toh), 32'(c < TOH_COLS));
            check(32'(rx_ec), 32'(c >= TOH_COLS));
            check(32'(rx_ptr_slot), 32'(r == 3 && c < TOH_COLS));
            if (r == 0 && c == 2) check(32'(rx_data), 32'(trace_v));
            // Envelope tracking checked only in the first whole frame after the first lock
            if (rx_frm == 1 && c >= TOH_COLS) begin
               check(32'(rx_spe_start), 32'(off == p));
               check(32'(rx_poh), 32'((off - p + ROWS * EC_COLS) % EC_COLS == 0));
            end
            rpos = (rpos + 1) % FRAME_BYTES;
            if (rpos == 0) rx_frm++;
         end
      end
   end

   // ==========================================================================
   // Main sequence, one step per transmitted frame
   initial begin
      void'($urandom(29080));
      rstn = 1'b0;
      tx_ptr = 10'h064;
      tx_ndf = 1'b0;
      tx_rdi = 1'b1;
      bad_a1 = 1'b0;
      trace_v = 8'($urandom);
      tx_trace = trace_v;
      tx_payload = 8'($urandom);
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
      wait_sig(tx_frame_start, 1'b1);
      wait_sig(tx_frame_start, 1'b1);
      wait_sig(tx_frame_start, 1'b1);
      check(32'(rx_ptr_val), 100);
      check(32'(rx_rdi), 1);
      check(32'(rx_trace), 32'(trace_v));
      tx_ptr <= 10'h064 ^ PTR_I_BITS;
      wait_sig(tx_frame_start, 1'b1);
      check(inc_n, 1);
      check(32'(rx_ptr_val), 101);
      check(b1_n, 0);
      // Frames 3 to 6 go out with a damaged first framing byte; the far end
      // samples the flag on the edge right after the frame start just seen
      tx_ptr <= 10'h065;
      bad_a1 <= 1'b1;
      wait_sig(tx_frame_start, 1'b1);
      tx_ptr <= 10'h065 ^ PTR_D_BITS;
      wait_sig(tx_frame_start, 1'b1);
      check(dec_n, 1);
      check(32'(rx_ptr_val), 100);
      check(b1_n, 1);
      tx_ptr <= 10'h1f4;
      tx_ndf <= 1'b1;
      wait_sig(tx_frame_start, 1'b1);
      check(ndf_n, 1);
      check(32'(rx_ptr_val), 500);
      check(inc_n + dec_n, 2);
      check(32'(rx_lock), 1);
      tx_ndf <= 1'b0;
      wait_sig(rx_lock, 1'b0);
      // Frame 7 goes out clean so framing can be found again
      bad_a1 <= 1'b0;
      wait_sig(rx_lock, 1'b1);
      check(lock_n, 2);
      finish_test();
   end
endmodule
